/* File: core/jdb_debug_port.sv */
// Purpose: Serial debug and boundary scan port with reset configuration.
// Assumes: tck from the external tester; clk is the chip clock at 10 MHz.
// Notes:   Commands cross to clk by toggle; data held until the next update.
// Behaviour
// - TAP state moves on rising test clock by mode-select level, standard graph.
// - Serial input sampled on rising edge; shift registers advance on falling edge.
// - Serial output changes on falling edge; driven only in shift states.
// - Test reset low forces test-logic-reset at once, no clock needed.
// - Normal mode: power-on low resets chip, test reset low resets port.
// - Emulator mode: both resets low enters hold; CPU stays stopped afterwards.
// - Hold ends only on boot command or fresh power-on reset assertion.
// - Emulator-mode pin high selects normal mode, low selects emulator mode.
// - Reset-assert command resets chip until reset-negate command is loaded.
// - Interrupt command raises a level-15 request handled as general exception.
// - Interrupt command not accepted in sleep or standby mode.
// - Recovery command 0001 wakes the chip from sleep.
// - Code 1111 selects one-bit bypass; system circuits unaffected.
// - Code 0100 sample/preload: pins and core pass straight through.
// - Sample latches pin and core values on rising edge in Capture-DR.
// - Preload moves shifted data into output latches; tester preloads first.
// - Code 0000 extest: pins driven from latches, pin levels captured.
// - Extest output-cell captures never reach pins; overwritten by shifting.
// - Chain holds generic pads only, not clock-related, reset or test-port pins.
// - Commands persist until replaced; interrupt command reverts to bypass.
// - Standby ignores debug commands while the TAP keeps running.
// - Control cell low drives pin from its output cell; high releases it.
`timescale 1ns/1ps
`default_nettype none
`include "jdb_map.svh"

module jdb_debug_port (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    tck,
  input  wire logic                    tms,
  input  wire logic                    tdi,
  input  wire logic                    trstN,
  output logic                         tdo,
  output logic                         tdoOe,
  input  wire logic                    powerOnResetN,
  input  wire logic                    emuModeSelN,
  input  wire logic                    sleepMode,
  input  wire logic                    standbyMode,
  input  wire logic                    intAck,
  input  wire jdb_pkg::jdb_pads_type   pads,
  output jdb_pkg::jdb_pins_type        padOut,
  output jdb_pkg::jdb_pins_type        padOe,
  output jdb_pkg::jdb_pins_type        coreIn,
  output jdb_pkg::jdb_status_type      status
);
  import jdb_pkg::*;

  jdb_tckp_type p_q, p_d;
  jdb_tckn_type n_q, n_d;
  jdb_sys_type  s_q, s_d;

  // ==========================================================
  // TAP state, rising test-clock edge
  function automatic jdb_tap_state_type tapNext(jdb_tap_state_type s, logic m);
    case (s)
      TAP_TLR:      tapNext = m ? TAP_TLR      : TAP_RTI;
      TAP_RTI:      tapNext = m ? TAP_SEL_DR   : TAP_RTI;
      TAP_SEL_DR:   tapNext = m ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   tapNext = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tapNext = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tapNext = m ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tapNext = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tapNext = m ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   tapNext = m ? TAP_SEL_DR   : TAP_RTI;
      TAP_SEL_IR:   tapNext = m ? TAP_TLR      : TAP_CAP_IR;
      TAP_CAP_IR:   tapNext = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tapNext = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tapNext = m ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tapNext = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tapNext = m ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   tapNext = m ? TAP_SEL_DR   : TAP_RTI;
      default:      tapNext = TAP_TLR;
    endcase
  endfunction : tapNext

  always_comb begin
    p_d       = p_q;
    p_d.state = tapNext(p_q.state, tms);
    p_d.tdiS  = tdi;
    // Snapshot is taken straight from clk-side flops; a scan capture is
    // asynchronous by nature, so one cell may catch a value mid-change.
    if (p_q.state == TAP_CAP_DR) begin
      // Chain covers the generic pads only; reset and test pins stay out
      for (int i = 0; i < JDB_NUM_PINS; i++) begin
        p_d.snap[i*`JDB_CELLS_PER_PIN + `JDB_CELL_IN]  = s_q.padS[i];
        p_d.snap[i*`JDB_CELLS_PER_PIN + `JDB_CELL_OUT] = s_q.padOut[i];
        p_d.snap[i*`JDB_CELLS_PER_PIN + `JDB_CELL_CTL] = ~s_q.padOe[i];
      end
    end
  end

  always_ff @(posedge tck or negedge trstN) begin
    if (!trstN) begin
      p_q <= '{state: TAP_TLR, tdiS: 1'h0, snap: '0};
    end else begin
      p_q <= p_d;
    end
  end

  // ==========================================================
  // Shift, update and output, falling test-clock edge
  logic drBsr;
  assign drBsr = (n_q.ir == `JDB_IR_SAMPLE) || (n_q.ir == `JDB_IR_EXTEST);

  always_comb begin
    n_d       = n_q;
    n_d.prev  = p_q.state;
    n_d.tdoOe = (p_q.state == TAP_SHIFT_DR) || (p_q.state == TAP_SHIFT_IR);
    // Capture values load on the first fall after Capture; shifting runs
    // on the fall after each Shift state so re-entry from Pause keeps data.
    if (n_q.prev == TAP_CAP_IR) begin
      n_d.irSh = `JDB_IR_CAPTURE;
    end else if (n_q.prev == TAP_SHIFT_IR) begin
      n_d.irSh = {p_q.tdiS, n_q.irSh[3:1]};
    end
    if (n_q.prev == TAP_CAP_DR) begin
      n_d.bypSh = `JDB_BYP_CAPTURE;
      n_d.bsrSh = p_q.snap;
    end else if (n_q.prev == TAP_SHIFT_DR) begin
      n_d.bypSh = p_q.tdiS;
      n_d.bsrSh = {p_q.tdiS, n_q.bsrSh[JDB_BSR_W-1:1]};
    end
    if (p_q.state == TAP_SHIFT_IR) begin
      n_d.tdo = n_d.irSh[0];
    end else if (p_q.state == TAP_SHIFT_DR) begin
      n_d.tdo = drBsr ? n_d.bsrSh[0] : n_d.bypSh;
    end
    if (n_q.ir == `JDB_IR_INTR) begin
      n_d.ir = `JDB_IR_BYPASS;
    end
    if (p_q.state == TAP_UPD_IR) begin
      n_d.ir     = n_q.irSh;
      n_d.cmd    = n_q.irSh;
      n_d.cmdTgl = ~n_q.cmdTgl;
    end else if (p_q.state == TAP_TLR && n_q.ir != `JDB_IR_BYPASS) begin
      n_d.ir     = `JDB_IR_BYPASS;
      n_d.cmd    = `JDB_IR_BYPASS;
      n_d.cmdTgl = ~n_q.cmdTgl;
    end
    if (p_q.state == TAP_UPD_DR && drBsr) begin
      n_d.latch  = n_q.bsrSh;
      n_d.updTgl = ~n_q.updTgl;
    end
  end

  always_ff @(negedge tck or negedge trstN) begin
    if (!trstN) begin
      n_q <= '{prev: TAP_TLR, ir: `JDB_IR_BYPASS, irSh: `JDB_IR_BYPASS,
               bypSh: 1'h0, bsrSh: '0, latch: '0, tdo: 1'h0, tdoOe: 1'h0,
               cmd: `JDB_IR_BYPASS, cmdTgl: 1'h0, updTgl: 1'h0};
    end else begin
      n_q <= n_d;
    end
  end

  assign tdo   = n_q.tdo;
  assign tdoOe = n_q.tdoOe;

  // ==========================================================
  // System clock side: reset configuration, commands, pads
  logic cmdNew;
  logic updNew;
  logic porS;
  logic trstS;
  logic emuMode;
  logic porFall;
  logic bootReq;
  assign porS    = s_q.porSy[1];
  assign trstS   = s_q.trstSy[1];
  assign emuMode = ~s_q.emuSy[1];
  assign cmdNew  = s_q.cmdSy[1] != s_q.cmdSeen;
  assign updNew  = s_q.updSy[1] != s_q.updSeen;
  assign porFall = s_q.porPrev & ~porS;
  // Standby blocks every command; the TAP itself keeps running
  assign bootReq = cmdNew && !standbyMode && n_q.cmd == `JDB_IR_BOOT;

  always_comb begin
    s_d         = s_q;
    s_d.porSy   = {s_q.porSy[0], powerOnResetN};
    s_d.emuSy   = {s_q.emuSy[0], emuModeSelN};
    s_d.trstSy  = {s_q.trstSy[0], trstN};
    s_d.cmdSy   = {s_q.cmdSy[0], n_q.cmdTgl};
    s_d.updSy   = {s_q.updSy[0], n_q.updTgl};
    s_d.padM    = pads.padIn;
    s_d.padS    = s_q.padM;
    s_d.cmdSeen = s_q.cmdSy[1];
    s_d.updSeen = s_q.updSy[1];
    s_d.porPrev = porS;
    s_d.st.wake = 1'h0;
    if (intAck) begin
      s_d.st.intReq   = 1'h0;
      s_d.st.intLevel = `JDB_INT_NONE;
    end
    if (cmdNew && !standbyMode) begin
      s_d.extest = n_q.cmd == `JDB_IR_EXTEST;
      case (n_q.cmd)
        `JDB_IR_RST_ASSERT: s_d.dbgRst = 1'h1;
        `JDB_IR_RST_NEGATE: s_d.dbgRst = 1'h0;
        `JDB_IR_RECOVER:    s_d.st.wake = sleepMode;
        `JDB_IR_INTR: begin
          if (!sleepMode) begin
            s_d.st.intReq   = 1'h1;
            s_d.st.intLevel = `JDB_INT_LEVEL;
          end
        end
        default: begin
        end
      endcase
    end
    if (!trstS) begin
      s_d.extest = 1'h0;
    end
    if (updNew) begin
      s_d.latch = n_q.latch;
    end
    if (bootReq || porFall) begin
      s_d.st.cpuHold = 1'h0;
    end
    if (emuMode && !porS && !trstS) begin
      s_d.st.cpuHold = 1'h1;
    end
    s_d.st.chipReset      = ~porS | s_q.dbgRst;
    s_d.st.debugPortReset = ~trstS;
    s_d.coreIn            = s_q.padS;
    for (int i = 0; i < JDB_NUM_PINS; i++) begin
      if (s_q.extest) begin
        s_d.padOut[i] = s_q.latch[i*`JDB_CELLS_PER_PIN + `JDB_CELL_OUT];
        s_d.padOe[i]  = ~s_q.latch[i*`JDB_CELLS_PER_PIN + `JDB_CELL_CTL];
      end else begin
        s_d.padOut[i] = pads.coreOut[i];
        s_d.padOe[i]  = pads.coreOe[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      // Synchronisers restart at idle pin levels; zeros would read as
      // emulator mode with both resets low and set a false reset hold.
      s_q         <= '0;
      s_q.porSy   <= '1;
      s_q.emuSy   <= '1;
      s_q.trstSy  <= '1;
      s_q.porPrev <= 1'h1;
    end else begin
      s_q <= s_d;
    end
  end

  assign padOut = s_q.padOut;
  assign padOe  = s_q.padOe;
  assign coreIn = s_q.coreIn;
  assign status = s_q.st;

  // ==========================================================
  // Checks
  sequence tmsFiveHigh;
    tms [*5];
  endsequence

  sequence intrAccepted;
    cmdNew && !standbyMode && !sleepMode && !intAck && n_q.cmd == `JDB_IR_INTR;
  endsequence

  chk_tap_reset_walk: assert property (
    @(posedge tck) disable iff (!trstN) tmsFiveHigh |=> p_q.state == TAP_TLR)
    else $error("five high mode-select edges did not reach reset");

  chk_tdo_drive_only: assert property (
    @(posedge tck) disable iff (!trstN)
    tdoOe == (p_q.state == TAP_SHIFT_DR || p_q.state == TAP_SHIFT_IR))
    else $error("serial output driven outside a shift state");

  chk_tlr_bypass: assert property (
    @(negedge tck) disable iff (!trstN)
    p_q.state == TAP_TLR |=> n_q.ir == `JDB_IR_BYPASS)
    else $error("reset state did not load bypass");

  chk_intr_reverts: assert property (
    @(negedge tck) disable iff (!trstN)
    n_q.ir == `JDB_IR_INTR && p_q.state != TAP_UPD_IR |=> n_q.ir == `JDB_IR_BYPASS)
    else $error("interrupt command did not revert to bypass");

  chk_int_request: assert property (
    @(posedge clk) disable iff (srst)
    intrAccepted |=> status.intReq && status.intLevel == `JDB_INT_LEVEL)
    else $error("interrupt command raised no level-15 request");

  chk_int_blocked: assert property (
    @(posedge clk) disable iff (srst)
    $rose(status.intReq) |-> !$past(sleepMode) && !$past(standbyMode))
    else $error("interrupt accepted in sleep or standby");

  chk_dbg_reset_held: assert property (
    @(posedge clk) disable iff (srst)
    cmdNew && !standbyMode && n_q.cmd == `JDB_IR_RST_ASSERT |=> ##1 status.chipReset)
    else $error("reset-assert command did not reset the chip");

  chk_por_reset: assert property (
    @(posedge clk) disable iff (srst) !porS |=> status.chipReset)
    else $error("power-on reset did not reset the chip");

  chk_hold_keeps: assert property (
    @(posedge clk) disable iff (srst)
    status.cpuHold && !bootReq && !porFall |=> status.cpuHold)
    else $error("reset hold left without boot or fresh power-on reset");

  for (genvar g = 0; g < JDB_NUM_PINS; g++) begin : g_pinChk
    chk_extest_drive: assert property (
      @(posedge clk) disable iff (srst)
      s_q.extest |=> padOut[g] == $past(s_q.latch[g*`JDB_CELLS_PER_PIN + `JDB_CELL_OUT])
                  && padOe[g] == !$past(s_q.latch[g*`JDB_CELLS_PER_PIN + `JDB_CELL_CTL]))
      else $error("extest pin not driven from its latch");
    chk_sample_pass: assert property (
      @(posedge clk) disable iff (srst)
      !s_q.extest |=> padOut[g] == $past(pads.coreOut[g]) && padOe[g] == $past(pads.coreOe[g]))
      else $error("pin not passed through outside extest");
  end

  // ==========================================================
  // Checks of captures, the bypass path and clk-side commands
  sequence bypShifting;
    p_q.state == TAP_SHIFT_DR && !drBsr;
  endsequence

  chk_ir_capture: assert property (
    @(negedge tck) disable iff (!trstN)
    n_q.prev == TAP_CAP_IR |=> n_q.irSh == `JDB_IR_CAPTURE)
    else $error("instruction capture value not loaded");

  chk_byp_capture: assert property (
    @(negedge tck) disable iff (!trstN)
    n_q.prev == TAP_CAP_DR |=> n_q.bypSh == `JDB_BYP_CAPTURE)
    else $error("bypass register did not capture zero");

  chk_byp_path: assert property (
    @(posedge tck) disable iff (!trstN)
    bypShifting ##1 bypShifting |-> tdo == $past(tdi))
    else $error("bypass path did not delay serial input by one bit");

  chk_preload_update: assert property (
    @(negedge tck) disable iff (!trstN)
    p_q.state == TAP_UPD_DR && drBsr |=> n_q.latch == $past(n_q.bsrSh))
    else $error("update did not load the output latches");

  chk_latch_cross: assert property (
    @(posedge clk) disable iff (srst)
    updNew |=> s_q.latch == $past(n_q.latch))
    else $error("output latches did not reach the chip clock side");

  chk_hold_entry: assert property (
    @(posedge clk) disable iff (srst)
    emuMode && !porS && !trstS |=> status.cpuHold)
    else $error("both resets low in emulator mode gave no reset hold");

  chk_boot_release: assert property (
    @(posedge clk) disable iff (srst)
    bootReq && !(emuMode && !porS && !trstS) |=> !status.cpuHold)
    else $error("boot command did not end the reset hold");

  chk_trst_extest: assert property (
    @(posedge clk) disable iff (srst)
    !trstS |=> !s_q.extest)
    else $error("test reset left extest in force");

  chk_standby_ignore: assert property (
    @(posedge clk) disable iff (srst)
    cmdNew && standbyMode && trstS
    |=> s_q.dbgRst == $past(s_q.dbgRst) && s_q.extest == $past(s_q.extest))
    else $error("command acted on in standby");

  chk_wake_pulse: assert property (
    @(posedge clk) disable iff (srst)
    status.wake |-> $past(sleepMode) ##1 !status.wake)
    else $error("wake pulse outside sleep or longer than one cycle");

endmodule : jdb_debug_port
`default_nettype wire

/* File: core/jdb_map.svh */
// Purpose: Constants of the serial debug port: command codes, capture values.
// Assumes: Included by the package and the top module; definitions only.
// Notes:   Command codes without a fixed code are placed in unused slots.
`ifndef JDB_MAP_SVH
`define JDB_MAP_SVH

`define JDB_IR_EXTEST      4'h0
`define JDB_IR_RECOVER     4'h1
`define JDB_IR_BOOT        4'h3
`define JDB_IR_SAMPLE      4'h4
`define JDB_IR_INTR        4'h5
`define JDB_IR_RST_ASSERT  4'h6
`define JDB_IR_RST_NEGATE  4'h7
`define JDB_IR_BYPASS      4'hF
`define JDB_IR_CAPTURE     4'h1
`define JDB_BYP_CAPTURE    1'h0
`define JDB_INT_LEVEL      4'hF
`define JDB_INT_NONE       4'h0
`define JDB_CELL_IN        0
`define JDB_CELL_OUT       1
`define JDB_CELL_CTL       2
`define JDB_CELLS_PER_PIN  3

`endif

/* File: core/jdb_pkg.sv */
// Purpose: Types of the serial debug port.
// Assumes: jdb_map.svh holds the numeric constants.
// Notes:   Chain length is fixed here because the state structs depend on it.
`include "jdb_map.svh"

package jdb_pkg;

  localparam int JDB_NUM_PINS = 8;
  localparam int JDB_BSR_W    = JDB_NUM_PINS * `JDB_CELLS_PER_PIN;

  typedef logic [3:0]              jdb_ir_type;
  typedef logic [JDB_NUM_PINS-1:0] jdb_pins_type;
  typedef logic [JDB_BSR_W-1:0]    jdb_bsr_type;

  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jdb_tap_state_type;

  // Rising test-clock edge state
  typedef struct packed {
    jdb_tap_state_type state;
    logic              tdiS;
    jdb_bsr_type       snap;
  } jdb_tckp_type;

  // Falling test-clock edge state
  typedef struct packed {
    jdb_tap_state_type prev;
    jdb_ir_type        ir;
    jdb_ir_type        irSh;
    logic              bypSh;
    jdb_bsr_type       bsrSh;
    jdb_bsr_type       latch;
    logic              tdo;
    logic              tdoOe;
    jdb_ir_type        cmd;
    logic              cmdTgl;
    logic              updTgl;
  } jdb_tckn_type;

  // Pad side, one pin per bit
  typedef struct packed {
    jdb_pins_type padIn;
    jdb_pins_type coreOut;
    jdb_pins_type coreOe;
  } jdb_pads_type;

  // Reset and debug status towards the chip
  typedef struct packed {
    logic       chipReset;
    logic       debugPortReset;
    logic       cpuHold;
    logic       intReq;
    logic [3:0] intLevel;
    logic       wake;
  } jdb_status_type;

  // System clock state
  typedef struct packed {
    logic [1:0]     porSy;
    logic [1:0]     emuSy;
    logic [1:0]     trstSy;
    logic [1:0]     cmdSy;
    logic           cmdSeen;
    logic [1:0]     updSy;
    logic           updSeen;
    jdb_pins_type   padM;
    jdb_pins_type   padS;
    logic           porPrev;
    logic           extest;
    logic           dbgRst;
    jdb_bsr_type    latch;
    jdb_status_type st;
    jdb_pins_type   padOut;
    jdb_pins_type   padOe;
    jdb_pins_type   coreIn;
  } jdb_sys_type;

endpackage : jdb_pkg

/* File: dv/jdb_tester.sv */
// Purpose: Model of the external test controller on the serial debug link.
// Assumes: Each scan starts in Run-Test/Idle or Test-Logic-Reset.
// Notes:   Link clock stands still between frames; tdi keeps its last bit.
`timescale 1ns/1ps
`default_nettype none

module jdb_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trstN,
  input  wire logic tdo,
  input  wire logic tdoOe
);
  logic [31:0] shOut;
  logic        oeOk;

  initial begin
    tck   = 1'b0;
    tms   = 1'b1;
    tdi   = 1'b0;
    trstN = 1'b0;
  end

  // Inputs move while tck is low; tdo read late in the low phase
  task automatic step(input logic m, input logic d, input int k);
    tms = m;
    tdi = d;
    #23;
    if (k >= 0) begin
      shOut[k] = tdo;
      oeOk     = oeOk & tdoOe;
    end
    #17 tck = 1'b1;
    #40 tck = 1'b0;
  endtask : step

  // Idle, select, capture, shift n bits LSB first, update, idle
  task automatic scan(input logic ir, input int n, input logic [31:0] d);
    shOut = '0;
    oeOk  = 1'b1;
    step(1'b0, tdi, -1);
    step(1'b1, tdi, -1);
    if (ir) step(1'b1, tdi, -1);
    step(1'b0, tdi, -1);
    step(1'b0, tdi, -1);
    for (int k = 0; k < n; k++) step(k == n - 1, d[k], k);
    step(1'b1, tdi, -1);
    step(1'b0, tdi, -1);
  endtask : scan

  task automatic toReset();
    repeat (5) step(1'b1, tdi, -1);
  endtask : toReset

  task automatic setTrst(input logic v);
    trstN = v;
    #30;
  endtask : setTrst
endmodule : jdb_tester
`default_nettype wire

/* File: dv/jtag_debug_and_boundary_scan_bench.sv */
// Purpose: Self-checking bench of the serial debug port.
// Assumes: Tester model owns the link clock; chip inputs change on clk fall.
// Notes:   Command waits rely on the fixed clock-crossing latency.
`timescale 1ns/1ps
`default_nettype none
`include "jdb_map.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end

module jtag_debug_and_boundary_scan_bench;
  import jdb_pkg::*;
  logic           clk, srst, tck, tms, tdi, trstN, tdo, tdoOe;
  logic           porN, emuSelN, slp, stb, intAck;
  logic           wakeSeen = 1'b0;
  jdb_pads_type   pads;
  jdb_pins_type   padOut, padOe, coreIn;
  jdb_status_type status;
  jdb_bsr_type    pat;
  logic [7:0]     d8;
  int             n_fail, n_compared;
  int             cyc = 0;

  jdb_debug_port jdb_debug_port_i (.clk(clk), .srst(srst), .tck(tck), .tms(tms),
    .tdi(tdi), .trstN(trstN), .tdo(tdo), .tdoOe(tdoOe), .powerOnResetN(porN),
    .emuModeSelN(emuSelN), .sleepMode(slp), .standbyMode(stb), .intAck(intAck),
    .pads(pads), .padOut(padOut), .padOe(padOe), .coreIn(coreIn), .status(status));
  jdb_tester jdb_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
    .tdo(tdo), .tdoOe(tdoOe));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Wake is a one-cycle pulse, so it is caught here
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (status.wake === 1'b1) wakeSeen <= 1'b1;
    if (cyc == 8000) begin
      n_fail++;
      test_done();
    end
  end

  function automatic jdb_bsr_type snapOf(jdb_pads_type p);
    jdb_bsr_type e;
    for (int i = 0; i < JDB_NUM_PINS; i++) begin
      e[`JDB_CELLS_PER_PIN*i+`JDB_CELL_IN]  = p.padIn[i];
      e[`JDB_CELLS_PER_PIN*i+`JDB_CELL_OUT] = p.coreOut[i];
      e[`JDB_CELLS_PER_PIN*i+`JDB_CELL_CTL] = ~p.coreOe[i];
    end
    return e;
  endfunction : snapOf

  function automatic jdb_pins_type cellsOf(jdb_bsr_type b, int c);
    jdb_pins_type r;
    for (int i = 0; i < JDB_NUM_PINS; i++) r[i] = b[`JDB_CELLS_PER_PIN*i+c];
    return r;
  endfunction : cellsOf

  task automatic waitClk(input int n);
    repeat (n) @(negedge clk);
  endtask : waitClk

  task automatic cmd(input jdb_ir_type c);
    jdb_tester_i.scan(1'b1, 4, {28'h0, c});
    waitClk(8);
  endtask : cmd

  task automatic bypassChk();
    d8 = 8'($urandom);
    jdb_tester_i.scan(1'b0, 8, {24'h0, d8});
    `CHK("bypass", {d8[6:0], `JDB_BYP_CAPTURE}, jdb_tester_i.shOut[7:0]);
  endtask : bypassChk

  task automatic test_done();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(32'h8a91));
    {srst, porN, emuSelN, slp, stb, intAck} = 6'b11_1000;
    pads       = '0;
    n_fail     = 0;
    n_compared = 0;
    waitClk(5);
    srst = 1'b0;
    waitClk(4);
    `CHK("holdIdle", 1'b0, status.cpuHold);
    for (int k = 0; k < 4; k++) begin
      porN = k[0];
      jdb_tester_i.setTrst(k[1]);
      waitClk(6);
      `CHK("chipReset", ~k[0], status.chipReset);
      `CHK("portReset", ~k[1], status.debugPortReset);
      `CHK("tdoOe", 1'b0, tdoOe);
    end
    $display("test reset_config done");
    jdb_tester_i.scan(1'b1, 4, 32'h0000_000F);
    `CHK("irCapture", `JDB_IR_CAPTURE, jdb_tester_i.shOut[3:0]);
    `CHK("shiftOe", 1'b1, jdb_tester_i.oeOk);
    `CHK("idleOe", 1'b0, tdoOe);
    bypassChk();
    for (int w = 0; w < 2; w++) begin
      jdb_tester_i.scan(1'b1, 4, {28'h0, `JDB_IR_SAMPLE});
      if (w == 0) jdb_tester_i.toReset();
      else begin
        jdb_tester_i.setTrst(1'b0);
        jdb_tester_i.setTrst(1'b1);
      end
      bypassChk();
    end
    $display("test tap_bypass done");
    cmd(`JDB_IR_SAMPLE);
    pads = jdb_pads_type'(jdb_bsr_type'($urandom));
    waitClk(6);
    `CHK("padOut", pads.coreOut, padOut);
    `CHK("padOe", pads.coreOe, padOe);
    `CHK("coreIn", pads.padIn, coreIn);
    pat = jdb_bsr_type'($urandom);
    jdb_tester_i.scan(1'b0, JDB_BSR_W, 32'(pat));
    `CHK("snapshot", snapOf(pads), jdb_tester_i.shOut[JDB_BSR_W-1:0]);
    waitClk(6);
    `CHK("preloadOut", pads.coreOut, padOut);
    {porN, emuSelN} = 2'b00;
    cmd(`JDB_IR_EXTEST);
    `CHK("extOut", cellsOf(pat, `JDB_CELL_OUT), padOut);
    `CHK("extOe", ~cellsOf(pat, `JDB_CELL_CTL), padOe);
    pads.padIn = JDB_NUM_PINS'($urandom);
    pat        = jdb_bsr_type'($urandom);
    waitClk(4);
    jdb_tester_i.scan(1'b0, JDB_BSR_W, 32'(pat));
    waitClk(8);
    `CHK("extIn", pads.padIn, cellsOf(jdb_tester_i.shOut[JDB_BSR_W-1:0], `JDB_CELL_IN));
    `CHK("extOut2", cellsOf(pat, `JDB_CELL_OUT), padOut);
    cmd(`JDB_IR_BYPASS);
    `CHK("bypassOut", pads.coreOut, padOut);
    {porN, emuSelN} = 2'b11;
    waitClk(6);
    $display("test boundary_scan done");
    stb = 1'b1;
    cmd(`JDB_IR_RST_ASSERT);
    cmd(`JDB_IR_INTR);
    `CHK("stbReset", 1'b0, status.chipReset);
    `CHK("stbInt", 1'b0, status.intReq);
    stb = 1'b0;
    slp = 1'b1;
    cmd(`JDB_IR_INTR);
    `CHK("slpInt", 1'b0, status.intReq);
    cmd(`JDB_IR_RECOVER);
    `CHK("wake", 1'b1, wakeSeen);
    slp = 1'b0;
    cmd(`JDB_IR_INTR);
    `CHK("intReq", 1'b1, status.intReq);
    `CHK("intLevel", `JDB_INT_LEVEL, status.intLevel);
    intAck = 1'b1;
    waitClk(1);
    intAck = 1'b0;
    waitClk(2);
    `CHK("intClear", 1'b0, status.intReq);
    bypassChk();
    cmd(`JDB_IR_RST_ASSERT);
    waitClk(20);
    `CHK("rstAssert", 1'b1, status.chipReset);
    cmd(`JDB_IR_RST_NEGATE);
    `CHK("rstNegate", 1'b0, status.chipReset);
    $display("test commands done");
    for (int k = 0; k < 3; k++) begin
      emuSelN = (k == 0);
      porN    = 1'b0;
      jdb_tester_i.setTrst(1'b0);
      waitClk(6);
      porN = 1'b1;
      waitClk(6);
      jdb_tester_i.setTrst(1'b1);
      waitClk(6);
      `CHK("cpuHold", k != 0, status.cpuHold);
      if (k == 1) cmd(`JDB_IR_BOOT);
      else begin
        porN = 1'b0;
        waitClk(6);
        porN = 1'b1;
        waitClk(6);
      end
      `CHK("holdEnd", 1'b0, status.cpuHold);
    end
    $display("test reset_hold done");
    test_done();
  end
endmodule : jtag_debug_and_boundary_scan_bench
`default_nettype wire
